// ===== aptc_pkg.sv
// shared constants and types for the conversion pair trigger controller
package aptc_pkg;

    // sizes
    localparam int NUM_PAIRS = 4;
    localparam int REG_W = 16;
    localparam int ADDR_W = 4;
    localparam int SEL_W = 5;
    localparam int HALF_W = 8;
    localparam int NUM_SRC = 32;
    localparam int PAIR_W = 2;

    // register addresses on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_CTRL_LO = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_HI = 4'h1;
    localparam logic [REG_W-1:0] CTRL_RESET = 16'h0000;

    // field positions inside one half of a register; the upper pair sits HALF_W higher
    localparam int IRQ_EN_POS = 7;
    localparam int PEND_POS = 6;
    localparam int SOFT_POS = 5;
    localparam int SEL_LSB = 0;

    // trigger source selector codes
    localparam logic [SEL_W-1:0] SRC_NONE = 5'h00;
    localparam logic [SEL_W-1:0] SRC_SOFT_ONE = 5'h01;
    localparam logic [SEL_W-1:0] SRC_SOFT_ALL = 5'h02;
    localparam logic [SEL_W-1:0] SRC_PWM_SPECIAL = 5'h03;
    localparam logic [SEL_W-1:0] SRC_PWM_PRI_BASE = 5'h04;
    localparam logic [SEL_W-1:0] SRC_TMR1 = 5'h0c;
    localparam logic [SEL_W-1:0] SRC_PWM_SPECIAL2 = 5'h0d;
    localparam logic [SEL_W-1:0] SRC_PWM_SEC_BASE = 5'h0e;
    localparam logic [SEL_W-1:0] SRC_PWM_LIM_BASE = 5'h17;
    localparam logic [SEL_W-1:0] SRC_TMR2 = 5'h1f;
    localparam int PWM_PRI_N = 8;
    localparam int PWM_SEC_N = 9;
    localparam int PWM_LIM_N = 8;

    // single-cycle trigger pulses from the pwm and timer logic and the global software trigger
    typedef struct packed {
        logic tmr2_period;
        logic [PWM_LIM_N-1:0] pwm_limit;
        logic [PWM_SEC_N-1:0] pwm_secondary;
        logic pwm_special2;
        logic tmr1_period;
        logic [PWM_PRI_N-1:0] pwm_primary;
        logic pwm_special;
        logic soft_all;
    } aptc_trig_t;

    // software-owned fields of one pair
    typedef struct packed {
        logic irq_enable;
        logic soft_trigger;
        logic [SEL_W-1:0] source_select;
    } aptc_pair_ctrl_t;

    // conversion request or completion naming a pair
    typedef struct packed {
        logic valid;
        logic [PAIR_W-1:0] pair;
    } aptc_conv_t;

    typedef enum logic {ARB_IDLE, ARB_OFFER} aptc_arb_state_t;

endpackage

// ===== aptc_pair_trigger_control.sv
// trigger, pending and interrupt control for conversion pairs 4/5, 6/7, 8/9 and 10/11
// Summary of operation
// - enable bit 15 of first register gates interrupt when pair 7/6 completes.
// - enable bit 7 of first register gates interrupt for pair 5/4.
// - enable bit 7 of second register gates interrupt for pair 9/8.
// - pending bit 14 sets on pair 7/6 trigger, clears on its completion.
// - pending bit 6 of second register follows trigger and completion of pair 9/8.
// - software trigger bit starts conversion only with individual software source selected.
// - hardware clears software trigger bit when it sets the pending flag with selector one selected.
// - bits 12 to 8 select the upper pair trigger source.
// - bits 4 to 0 select the lower pair trigger source.
// - upper selector of second register serves pair 11/10.
// - selector zero disables conversion; no trigger starts the pair.
// - selector one picks the pair's own software trigger bit.
// - selector two picks the shared global software trigger.
// - selector three picks pwm special event, thirteen the secondary special event.
// - selectors four to eleven pick pwm generator 1 to 8 primary triggers.
// - selector twelve picks timer1 period match.
// - selectors fourteen to twenty-two pick pwm generator 1 to 9 secondary triggers.
// - selectors twenty-three to thirty pick pwm 1 to 8 current-limit triggers.
// - selector thirty-one picks timer2 period match.
// - pending requests wait until the converter accepts them.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module aptc_pair_trigger_control
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [aptc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [aptc_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [aptc_pkg::REG_W-1:0] reg_rdata,
    // trigger pulses
    input wire aptc_pkg::aptc_trig_t trig_in,
    // converter request handshake
    output aptc_pkg::aptc_conv_t conv_req,
    input wire logic conv_ready,
    // converter completion
    input wire aptc_pkg::aptc_conv_t conv_done,
    // per-pair interrupt requests
    output logic [aptc_pkg::NUM_PAIRS-1:0] pair_irq
);

    // register state
    aptc_pkg::aptc_pair_ctrl_t ctrl [aptc_pkg::NUM_PAIRS];
    logic [aptc_pkg::NUM_PAIRS-1:0] pending;
    logic [aptc_pkg::NUM_PAIRS-1:0] issued;
    logic [aptc_pkg::REG_W-1:0] next_rdata;

    // per-pair decoded events
    logic [aptc_pkg::NUM_PAIRS-1:0] trig_hit;
    logic [aptc_pkg::NUM_PAIRS-1:0] done_hit;
    logic [aptc_pkg::NUM_PAIRS-1:0] new_event;
    logic [aptc_pkg::NUM_PAIRS-1:0] grant;
    logic [aptc_pkg::NUM_PAIRS-1:0] waiting;
    logic [aptc_pkg::NUM_PAIRS-1:0] next_pending;
    logic [aptc_pkg::NUM_PAIRS-1:0] next_issued;
    logic [aptc_pkg::NUM_PAIRS-1:0] next_irq;
    logic [aptc_pkg::HALF_W-1:0] pair_view [aptc_pkg::NUM_PAIRS];

    // arbiter
    aptc_pkg::aptc_arb_state_t arb_state;
    aptc_pkg::aptc_arb_state_t next_arb_state;
    logic [aptc_pkg::PAIR_W-1:0] offer_pair;
    logic [aptc_pkg::PAIR_W-1:0] next_offer_pair;
    logic [aptc_pkg::PAIR_W-1:0] pick_pair;
    logic any_waiting;
    logic accept;

    // address decode
    wire wr_lo = reg_wr && (reg_addr == aptc_pkg::ADDR_CTRL_LO);
    wire wr_hi = reg_wr && (reg_addr == aptc_pkg::ADDR_CTRL_HI);
    wire rd_lo = reg_rd && (reg_addr == aptc_pkg::ADDR_CTRL_LO);
    wire rd_hi = reg_rd && (reg_addr == aptc_pkg::ADDR_CTRL_HI);

    // source vector shared by all pairs; codes 0 and 1 stay low here
    logic [aptc_pkg::NUM_SRC-1:0] common_src;

    always_comb
    begin
        common_src = '0;
        common_src[aptc_pkg::SRC_SOFT_ALL] = trig_in.soft_all;
        common_src[aptc_pkg::SRC_PWM_SPECIAL] = trig_in.pwm_special;
        common_src[aptc_pkg::SRC_PWM_PRI_BASE +: aptc_pkg::PWM_PRI_N] =
            trig_in.pwm_primary;
        common_src[aptc_pkg::SRC_TMR1] = trig_in.tmr1_period;
        common_src[aptc_pkg::SRC_PWM_SPECIAL2] = trig_in.pwm_special2;
        common_src[aptc_pkg::SRC_PWM_SEC_BASE +: aptc_pkg::PWM_SEC_N] =
            trig_in.pwm_secondary;
        common_src[aptc_pkg::SRC_PWM_LIM_BASE +: aptc_pkg::PWM_LIM_N] =
            trig_in.pwm_limit;
        common_src[aptc_pkg::SRC_TMR2] = trig_in.tmr2_period;
    end

    genvar p;
    generate
        for (p = 0; p < aptc_pkg::NUM_PAIRS; p++)
        begin : g_pair
            // lower pair of each register in the low half, upper pair in the high half
            localparam int OFS = (p % 2) * aptc_pkg::HALF_W;
            localparam logic [aptc_pkg::PAIR_W-1:0] IDX = aptc_pkg::PAIR_W'(p);

            wire pair_wr = (p < 2) ? wr_lo : wr_hi;
            wire [aptc_pkg::HALF_W-1:0] wr_half = reg_wdata[OFS +: aptc_pkg::HALF_W];
            logic [aptc_pkg::NUM_SRC-1:0] pair_src;

            always_comb
            begin
                pair_src = common_src;
                pair_src[aptc_pkg::SRC_SOFT_ONE] = ctrl[p].soft_trigger;
            end

            // only the named source reaches the pair
            assign trig_hit[p] = pair_src[ctrl[p].source_select];
            assign done_hit[p] = conv_done.valid && (conv_done.pair == IDX);
            // a trigger meeting its own completion starts a fresh request
            assign new_event[p] = trig_hit[p] && (!pending[p] || done_hit[p]);
            assign next_pending[p] = new_event[p] | (pending[p] & ~done_hit[p]);
            assign next_issued[p] = !new_event[p] && !done_hit[p] && (issued[p] | grant[p]);
            assign waiting[p] = pending[p] & ~issued[p];
            assign next_irq[p] = done_hit[p] && pending[p] && ctrl[p].irq_enable;
            assign grant[p] = accept && (offer_pair == IDX);

            assign pair_view[p] = {ctrl[p].irq_enable, pending[p], ctrl[p].soft_trigger,
                ctrl[p].source_select};

            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    ctrl[p] <= '0;
                end
                else if (pair_wr)
                begin
                    ctrl[p].irq_enable <= wr_half[aptc_pkg::IRQ_EN_POS];
                    ctrl[p].soft_trigger <= wr_half[aptc_pkg::SOFT_POS];
                    ctrl[p].source_select <=
                        wr_half[aptc_pkg::SEL_LSB +: aptc_pkg::SEL_W];
                end
                // cleared only by the edge that sets pending, so an absorbed start stays armed
                else if (new_event[p] && ctrl[p].source_select == aptc_pkg::SRC_SOFT_ONE)
                begin
                    ctrl[p].soft_trigger <= 1'b0;
                end
            end
        end
    endgenerate

    // lowest waiting pair wins the converter
    always_comb
    begin
        pick_pair = '0;
        for (int i = aptc_pkg::NUM_PAIRS - 1; i >= 0; i--)
        begin
            if (waiting[i])
            begin
                pick_pair = i[aptc_pkg::PAIR_W-1:0];
            end
        end
    end

    assign any_waiting = |waiting;
    assign accept = (arb_state == aptc_pkg::ARB_OFFER) && conv_ready;

    always_comb
    begin
        next_arb_state = arb_state;
        next_offer_pair = offer_pair;
        case (arb_state)
            aptc_pkg::ARB_IDLE:
            begin
                if (any_waiting)
                begin
                    next_arb_state = aptc_pkg::ARB_OFFER;
                    next_offer_pair = pick_pair;
                end
            end
            aptc_pkg::ARB_OFFER:
            begin
                if (conv_ready)
                begin
                    next_arb_state = aptc_pkg::ARB_IDLE;
                end
            end
            default:
            begin
                next_arb_state = aptc_pkg::ARB_IDLE;
            end
        endcase
    end

    assign conv_req.valid = (arb_state == aptc_pkg::ARB_OFFER);
    assign conv_req.pair = offer_pair;

    // read mux; unmapped addresses read zero
    always_comb
    begin
        next_rdata = '0;
        if (rd_lo)
        begin
            next_rdata = {pair_view[1], pair_view[0]};
        end
        else if (rd_hi)
        begin
            next_rdata = {pair_view[3], pair_view[2]};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending <= '0;
            issued <= '0;
            pair_irq <= '0;
        end
        else
        begin
            pending <= next_pending;
            issued <= next_issued;
            pair_irq <= next_irq;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arb_state <= aptc_pkg::ARB_IDLE;
            offer_pair <= '0;
            reg_rdata <= aptc_pkg::CTRL_RESET;
        end
        else
        begin
            arb_state <= next_arb_state;
            offer_pair <= next_offer_pair;
            reg_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ===== aptc_pair_trigger_control_assertions.sv
// port-level checks for the pair trigger controller
`timescale 1ns/1ps
`default_nettype none
module aptc_checker
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [aptc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [aptc_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [aptc_pkg::REG_W-1:0] reg_rdata,
    // converter and interrupts
    input wire aptc_pkg::aptc_conv_t conv_req,
    input wire logic conv_ready,
    input wire aptc_pkg::aptc_conv_t conv_done,
    input wire logic [aptc_pkg::NUM_PAIRS-1:0] pair_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_rd;
        reg_wr && reg_addr == aptc_pkg::ADDR_CTRL_LO ##1 reg_rd && reg_addr == aptc_pkg::ADDR_CTRL_LO;
    endsequence
    sequence s_soft_rd;
        reg_wr && reg_addr == aptc_pkg::ADDR_CTRL_LO && reg_wdata[5:0] == 6'h21
            ##4 reg_rd && reg_addr == aptc_pkg::ADDR_CTRL_LO;
    endsequence
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    property p_unmapped;
        reg_rd && reg_addr > aptc_pkg::ADDR_CTRL_HI |=> reg_rdata == 16'h0000;
    endproperty
    property p_readback;
        s_wr_rd |=> (reg_rdata & 16'h9f9f) == ($past(reg_wdata, 2) & 16'h9f9f);
    endproperty
    property p_soft_pend;
        s_soft_rd |=> reg_rdata[6];
    endproperty
    property p_req_hold;
        conv_req.valid && !conv_ready |=> conv_req.valid && $stable(conv_req.pair);
    endproperty
    property p_req_drop;
        conv_req.valid && conv_ready |=> !conv_req.valid;
    endproperty
    property p_irq_cause;
        pair_irq != 4'h0 |-> $past(conv_done.valid) && pair_irq == 4'h1 << $past(conv_done.pair);
    endproperty
    property p_reset_quiet;
        $rose(rst_n) |-> reg_rdata == 16'h0000 && !conv_req.valid && pair_irq == 4'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_readback: assert property (p_readback) else $error("field readback");
    a_soft_pend: assert property (p_soft_pend) else $error("soft start");
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    a_req_drop: assert property (p_req_drop) else $error("request kept");
    a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset state");
endmodule
bind aptc_pair_trigger_control aptc_checker chk_u (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .conv_req, .conv_ready, .conv_done, .pair_irq);
`default_nettype wire

// ===== aptc_conv_model.sv
// behavioural converter serving one pair request at a time
`timescale 1ns/1ps
`default_nettype none
module aptc_conv_model
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request side
    input wire aptc_pkg::aptc_conv_t conv_req,
    input wire logic slow,
    output logic conv_ready,
    output aptc_pkg::aptc_conv_t conv_done
);
    int cnt;
    logic [1:0] held;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            held <= 2'h0;
            conv_ready <= 1'b0;
            conv_done <= '0;
        end
        else
        begin
            conv_done.valid <= cnt == 1;
            // idle pair field keeps changing so nothing leans on a stale value
            conv_done.pair <= cnt == 1 ? held : ~conv_done.pair;
            if (cnt > 0)
                cnt <= cnt - 1;
            else if (conv_req.valid && conv_ready)
            begin
                held <= conv_req.pair;
                cnt <= 3;
                conv_ready <= 1'b0;
            end
            else
                conv_ready <= !slow || !conv_ready;
        end
    end
endmodule
`default_nettype wire

// ===== aptc_pair_trigger_control_tb.sv
// self-checking bench for the pair trigger controller
`timescale 1ns/1ps
`default_nettype none
module aptc_pair_trigger_control_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] pair_irq;
    logic conv_ready;
    logic [3:0] lo_a = aptc_pkg::ADDR_CTRL_LO;
    logic [3:0] hi_a = aptc_pkg::ADDR_CTRL_HI;
    aptc_pkg::aptc_trig_t trig_in = '0;
    aptc_pkg::aptc_conv_t conv_req;
    aptc_pkg::aptc_conv_t conv_done;
    int err_total = 0;
    int check_count = 0;
    always #25 core_clk = ~core_clk;
    aptc_pair_trigger_control dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .trig_in, .conv_req, .conv_ready, .conv_done, .pair_irq);
    aptc_conv_model conv_u (.core_clk, .rst_n, .conv_req, .slow, .conv_ready, .conv_done);
    task automatic complete_run;
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // optional write slot, then optional read slot of the same address
    task automatic acc(input bit w, input bit r, input logic [3:0] a, input logic [15:0] d, e);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= r;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        if (r)
            chk(reg_rdata, e);
        @(posedge core_clk);
    endtask
    task automatic pulse(input logic [29:0] t);
        trig_in <= t;
        @(posedge core_clk);
        trig_in <= '0;
    endtask
    // wait for the pair's completion, then its interrupt and cleared pending flag
    task automatic fin(input int p, input bit en, input logic [15:0] w);
        int n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (!(conv_done.valid === 1'b1 && conv_done.pair === p[1:0]) && n < 100);
        @(posedge core_clk);
        #1;
        chk({12'h000, pair_irq}, {12'h000, en ? 4'h1 << p : 4'h0});
        @(posedge core_clk);
        acc(0, 1, p > 1 ? hi_a : lo_a, 16'h0000, w);
    endtask
    // selector codes from two upward follow the trigger bundle from its lsb
    function automatic int src_bit(input int s);
        return s - 2;
    endfunction
    initial
    begin
        int p, s, en, b;
        logic [15:0] w;
        logic [3:0] seen, first;
        p = $urandom(43);
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        acc(0, 1, lo_a, 16'h0000, 16'h0000);
        acc(0, 1, hi_a, 16'h0000, 16'h0000);
        acc(0, 1, 4'h7, 16'h0000, 16'h0000);
        acc(1, 0, hi_a, 16'h2000, 16'h0000);
        pulse(30'h3fffffff);
        acc(0, 1, hi_a, 16'h0000, 16'h2000);
        for (s = 2; s < 32; s++)
        begin
            p = $urandom_range(3);
            en = $urandom_range(1);
            slow <= 1'($urandom_range(1));
            b = en * 128 + s;
            w = 16'(p[0] ? b << 8 : b);
            acc(1, 0, p[1] ? lo_a : hi_a, 16'h0000, 16'h0000);
            acc(1, 1, p[1] ? hi_a : lo_a, w, w);
            pulse(30'h1 << ((src_bit(s) + 1 + $urandom_range(27)) % 30));
            acc(0, 1, p[1] ? hi_a : lo_a, 16'h0000, w);
            pulse(30'h1 << src_bit(s));
            acc(0, 1, p[1] ? hi_a : lo_a, 16'h0000, w | (p[0] ? 16'h4000 : 16'h0040));
            fin(p, en[0], w);
        end
        slow <= 1'b0;
        acc(1, 0, hi_a, 16'h0000, 16'h0000);
        acc(1, 1, lo_a, 16'h0024, 16'h0024);
        acc(1, 0, lo_a, 16'h00a1, 16'h0000);
        acc(0, 1, lo_a, 16'h0000, 16'h00c1);
        fin(0, 1'b1, 16'h0081);
        acc(1, 0, lo_a, 16'h8282, 16'h0000);
        acc(1, 0, hi_a, 16'h8282, 16'h0000);
        slow <= 1'b1;
        pulse(30'h1);
        seen = 4'h0;
        first = 4'h0;
        repeat (120)
        begin
            @(posedge core_clk);
            #1;
            if (first === 4'h0)
                first = pair_irq;
            seen = seen | pair_irq;
        end
        chk({12'h000, first}, 16'h0001);
        chk({12'h000, seen}, 16'h000f);
        @(posedge core_clk);
        acc(1, 0, lo_a, 16'h9f9f, 16'h0000);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        acc(0, 1, lo_a, 16'h0000, 16'h0000);
        acc(0, 1, hi_a, 16'h0000, 16'h0000);
        complete_run;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire
